// ==== hdl/pei_pkg.sv ====
// Constants for the picture enhancer two-wire control block
package pei_pkg;
    localparam logic [6:0] PEI_SLAVE_ADDR = 7'h44;
    localparam logic [7:0] PEI_SUB_LUMA = 8'h10;
    localparam logic [7:0] PEI_SUB_PEAK = 8'h11;
    localparam logic [7:0] PEI_REG_RESET = 8'h01;
    localparam logic [7:0] PEI_LUMA_MASK = 8'h7F;
    localparam logic [7:0] PEI_PEAK_MASK = 8'hE3;
    localparam int PEI_LUMA_CTRANS_BIT = 5;
    localparam int PEI_LUMA_SANDC_BIT = 6;
    localparam int PEI_PEAK_CORING_BIT = 7;
    localparam int PEI_PEAK_DLY_BIT = 6;
    localparam int PEI_PEAK_FRQ_BIT = 5;
    localparam int PEI_BK_MIN = 4;
    localparam int PEI_BK_MAX = 31;
    localparam int PEI_DELAY_W = 11;
    // Delay weights in ns for luma bits 0..4
    localparam logic [10:0] PEI_DLY_W0 = 11'h02D;
    localparam logic [10:0] PEI_DLY_W1 = 11'h05A;
    localparam logic [10:0] PEI_DLY_W2 = 11'h0B4;
    localparam logic [10:0] PEI_DLY_W3 = 11'h0B4;
    localparam logic [10:0] PEI_DLY_W4 = 11'h1C2;
endpackage

// ==== hdl/pei_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pei_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ==== hdl/pei_ctrl.sv ====
// Two-wire write-only slave with enhancer control registers
`timescale 1ns/1ns
`default_nettype none
module pei_ctrl
    import pei_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic burst_key_in,
    input wire logic vblank_in,
    output logic [7:0] luma_reg,
    output logic [7:0] peak_reg,
    output logic [PEI_DELAY_W-1:0] luma_delay_ns,
    output logic colour_transient_enable,
    output logic sandcastle_level_select,
    output logic coring_enable,
    output logic peaking_delay_enable,
    output logic peaking_frequency_select,
    output logic [1:0] peaking_gain_field,
    output logic [4:0] burst_key_count,
    output logic delay_loop_active
);
    typedef enum logic [2:0] {
        PEI_IDLE = 3'b000,
        PEI_ADDR = 3'b001,
        PEI_SUB = 3'b010,
        PEI_DATA = 3'b011,
        PEI_ACK = 3'b100,
        PEI_SKIP = 3'b101
    } pei_state_e;

    logic [3:0] pin_s;
    logic scl_s, sda_s, bk_s, vb_s;
    pei_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in({scl_in, sda_in, burst_key_in, vblank_in}),
        .sync_out(pin_s)
    );
    assign {scl_s, sda_s, bk_s, vb_s} = pin_s;

    logic scl_d_ff, sda_d_ff, bk_d_ff;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            // Matches synchroniser reset level, no false edge
            bk_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            bk_d_ff <= bk_s;
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c, bk_rise;
    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;
    assign start_c = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_c = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    assign bk_rise = bk_s && !bk_d_ff;

    pei_state_e state_ff, nxt_state, ret_ff, nxt_ret;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] sub_ff, nxt_sub;
    logic [7:0] luma_ff, nxt_luma, peak_ff, nxt_peak;
    logic ack_ff, nxt_ack;
    logic sda_oe_n_ff, nxt_sda_oe_n;

    always_comb begin
        nxt_state = state_ff;
        nxt_ret = ret_ff;
        nxt_shift = shift_ff;
        nxt_bit = bit_ff;
        nxt_sub = sub_ff;
        nxt_luma = luma_ff;
        nxt_peak = peak_ff;
        nxt_ack = ack_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        if (start_c) begin
            nxt_state = PEI_ADDR;
            nxt_bit = 4'h0;
            nxt_sda_oe_n = 1'b1;
        end else if (stop_c) begin
            nxt_state = PEI_IDLE;
            nxt_sda_oe_n = 1'b1;
        end else begin
            case (state_ff)
                PEI_ADDR, PEI_SUB, PEI_DATA: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_bit = bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == 4'h8) begin
                        nxt_bit = 4'h0;
                        nxt_ack = 1'b0;
                        nxt_ret = state_ff;
                        nxt_state = PEI_ACK;
                        if (state_ff == PEI_ADDR) begin
                            if (shift_ff == {PEI_SLAVE_ADDR, 1'b0}) begin
                                nxt_ack = 1'b1;
                                nxt_ret = PEI_SUB;
                            end
                        end else if (state_ff == PEI_SUB) begin
                            if (shift_ff == PEI_SUB_LUMA || shift_ff == PEI_SUB_PEAK) begin
                                nxt_ack = 1'b1;
                                nxt_sub = shift_ff;
                                nxt_ret = PEI_DATA;
                            end
                        end else begin
                            if (sub_ff == PEI_SUB_LUMA) begin
                                nxt_luma = shift_ff & PEI_LUMA_MASK;
                                nxt_ack = 1'b1;
                            end else if (sub_ff == PEI_SUB_PEAK) begin
                                nxt_peak = shift_ff & PEI_PEAK_MASK;
                                nxt_ack = 1'b1;
                            end
                            if (sub_ff <= PEI_SUB_PEAK) begin
                                nxt_sub = sub_ff + 8'h01;
                            end
                        end
                        nxt_sda_oe_n = !nxt_ack;
                        if (!nxt_ack) begin
                            nxt_state = PEI_SKIP;
                        end
                    end
                end
                PEI_ACK: begin
                    if (scl_fall) begin
                        nxt_sda_oe_n = 1'b1;
                        nxt_state = ret_ff;
                    end
                end
                PEI_SKIP: begin
                    nxt_sda_oe_n = 1'b1;
                end
                default: begin
                    nxt_sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff <= PEI_IDLE;
            ret_ff <= PEI_IDLE;
            shift_ff <= 8'h00;
            bit_ff <= 4'h0;
            sub_ff <= 8'h00;
            luma_ff <= PEI_REG_RESET;
            peak_ff <= PEI_REG_RESET;
            ack_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            ret_ff <= nxt_ret;
            shift_ff <= nxt_shift;
            bit_ff <= nxt_bit;
            sub_ff <= nxt_sub;
            luma_ff <= nxt_luma;
            peak_ff <= nxt_peak;
            ack_ff <= nxt_ack;
            sda_oe_n_ff <= nxt_sda_oe_n;
        end
    end

    // Burst-key counting within vertical blanking
    logic [4:0] bk_cnt_ff, nxt_bk_cnt;
    logic loop_ff, nxt_loop;
    always_comb begin
        nxt_bk_cnt = bk_cnt_ff;
        nxt_loop = loop_ff;
        if (!vb_s) begin
            nxt_bk_cnt = 5'h00;
            nxt_loop = 1'b0;
        end else if (bk_rise) begin
            if (bk_cnt_ff == 5'(PEI_BK_MAX)) begin
                nxt_bk_cnt = 5'h01;
            end else begin
                nxt_bk_cnt = bk_cnt_ff + 5'h01;
            end
            nxt_loop = (nxt_bk_cnt >= 5'(PEI_BK_MIN));
        end
    end

    logic [PEI_DELAY_W-1:0] nxt_delay;
    always_comb begin
        nxt_delay = (luma_ff[0] ? PEI_DLY_W0 : 11'h000)
                  + (luma_ff[1] ? PEI_DLY_W1 : 11'h000)
                  + (luma_ff[2] ? PEI_DLY_W2 : 11'h000)
                  + (luma_ff[3] ? PEI_DLY_W3 : 11'h000)
                  + (luma_ff[4] ? PEI_DLY_W4 : 11'h000);
    end

    logic [PEI_DELAY_W-1:0] delay_ff;
    logic ctrans_ff, sandc_ff, coring_ff, pdly_ff, frq_ff;
    logic [1:0] gain_ff;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bk_cnt_ff <= 5'h00;
            loop_ff <= 1'b0;
            delay_ff <= PEI_DLY_W0;
            ctrans_ff <= 1'b0;
            sandc_ff <= 1'b0;
            coring_ff <= 1'b0;
            pdly_ff <= 1'b0;
            frq_ff <= 1'b0;
            gain_ff <= 2'h1;
        end else begin
            bk_cnt_ff <= nxt_bk_cnt;
            loop_ff <= nxt_loop;
            delay_ff <= nxt_delay;
            ctrans_ff <= luma_ff[PEI_LUMA_CTRANS_BIT];
            sandc_ff <= luma_ff[PEI_LUMA_SANDC_BIT];
            coring_ff <= peak_ff[PEI_PEAK_CORING_BIT];
            pdly_ff <= peak_ff[PEI_PEAK_DLY_BIT];
            frq_ff <= peak_ff[PEI_PEAK_FRQ_BIT];
            gain_ff <= peak_ff[1:0];
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = sda_oe_n_ff;
    assign luma_reg = luma_ff;
    assign peak_reg = peak_ff;
    assign luma_delay_ns = delay_ff;
    assign colour_transient_enable = ctrans_ff;
    assign sandcastle_level_select = sandc_ff;
    assign coring_enable = coring_ff;
    assign peaking_delay_enable = pdly_ff;
    assign peaking_frequency_select = frq_ff;
    assign peaking_gain_field = gain_ff;
    assign burst_key_count = bk_cnt_ff;
    assign delay_loop_active = loop_ff;

    property p_reset_values;
        @(posedge clk) $rose(reset_n) |-> luma_ff == PEI_REG_RESET && peak_ff == PEI_REG_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
    property p_reserved_zero;
        @(posedge clk) disable iff (!reset_n) !luma_ff[7] && peak_ff[4:2] == 3'b000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
    property p_ack_drives_low;
        @(posedge clk) disable iff (!reset_n) state_ff == PEI_ACK |-> !sda_oe_n_ff;
    endproperty
    a_ack_drives_low: assert property (p_ack_drives_low) else $error("ack not driven");
    property p_skip_released;
        @(posedge clk) disable iff (!reset_n) state_ff == PEI_SKIP |-> sda_oe_n_ff;
    endproperty
    a_skip_released: assert property (p_skip_released) else $error("nack drove line");
    property p_addr_ack;
        @(posedge clk) disable iff (!reset_n)
            state_ff == PEI_ACK && ret_ff == PEI_SUB |-> shift_ff == {PEI_SLAVE_ADDR, 1'b0};
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("wrong address acked");
    sequence s_addr_byte_done;
        state_ff == PEI_ADDR && scl_fall && bit_ff == 4'h8;
    endsequence
    property p_gencall;
        @(posedge clk) disable iff (!reset_n)
            s_addr_byte_done ##0 shift_ff == 8'h00 |=> state_ff == PEI_SKIP;
    endproperty
    a_gencall: assert property (p_gencall) else $error("general call acked");
    property p_sub_range;
        @(posedge clk) disable iff (!reset_n)
            state_ff == PEI_ACK && ret_ff == PEI_DATA && $past(state_ff) == PEI_SUB
            |-> sub_ff == PEI_SUB_LUMA || sub_ff == PEI_SUB_PEAK;
    endproperty
    a_sub_range: assert property (p_sub_range) else $error("bad subaddress acked");
    property p_bk_wrap;
        @(posedge clk) disable iff (!reset_n) bk_cnt_ff <= 5'(PEI_BK_MAX) && bk_cnt_ff != 5'h00
            |-> ##1 (bk_cnt_ff == $past(bk_cnt_ff) || bk_cnt_ff == $past(bk_cnt_ff) + 5'h01
            || bk_cnt_ff <= 5'h01);
    endproperty
    a_bk_wrap: assert property (p_bk_wrap) else $error("burst count jumped");
endmodule
`default_nettype wire

// ==== tb/pei_master_model.sv ====
// Two-wire bus master model for the control block
`timescale 1ns/1ns
`default_nettype none
module pei_master_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl_out,
    output logic sda_low
);
    initial begin
        scl_out = 1'b1;
        sda_low = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        sda_low = 1'b0;
        scl_out = 1'b1;
        idle(5);
        sda_low = 1'b1;
        idle(5);
    endtask
    // data changes only while clock low
    task automatic send_bit(input logic b, output logic seen);
        scl_out = 1'b0;
        idle(2);
        sda_low = ~b;
        idle(3);
        scl_out = 1'b1;
        idle(2);
        seen = sda_wire;
        idle(3);
    endtask
    // MSB first, line released for acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i], seen);
        end
        send_bit(1'b1, seen);
        ack = ~seen;
    endtask
    task automatic stop();
        scl_out = 1'b0;
        idle(2);
        sda_low = 1'b1;
        idle(3);
        scl_out = 1'b1;
        idle(5);
        sda_low = 1'b0;
        idle(5);
    endtask
endmodule
`default_nettype wire

// ==== tb/picture_enhancer_i2c_control_test.sv ====
// Self-checking bench for the enhancer control block
`timescale 1ns/1ns
`default_nettype none
module picture_enhancer_i2c_control_test;
    import pei_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic burst_key_in = 1'b0;
    logic vblank_in = 1'b0;
    logic scl, mst_low, sda_out, sda_oe_n, ctrans, sandc, coring, pdly, frq, active;
    logic [7:0] luma_reg, peak_reg;
    logic [10:0] dly;
    logic [1:0] gain;
    logic [4:0] cnt, acks;
    int err_count = 0;
    int total_checks = 0;
    int wts[6] = '{45, 90, 180, 180, 450, 0};
    wire logic sda_wire = ~mst_low & (sda_oe_n | sda_out);
    initial begin
        forever #2 clk = ~clk;
    end
    pei_master_model mst (.clk(clk), .sda_wire(sda_wire), .scl_out(scl), .sda_low(mst_low));
    pei_ctrl dut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .burst_key_in(burst_key_in),
        .vblank_in(vblank_in), .luma_reg(luma_reg), .peak_reg(peak_reg),
        .luma_delay_ns(dly), .colour_transient_enable(ctrans), .sandcastle_level_select(sandc),
        .coring_enable(coring), .peaking_delay_enable(pdly), .peaking_frequency_select(frq),
        .peaking_gain_field(gain), .burst_key_count(cnt), .delay_loop_active(active));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Whole transfer: address, subaddress, n data bytes
    task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d0,
        input logic [7:0] d1, input logic [7:0] d2, input int n, output logic [4:0] ak);
        logic [7:0] b[5];
        logic k;
        b = '{a, s, d0, d1, d2};
        ak = 5'h00;
        mst.start();
        for (int i = 0; i < n + 2; i++) begin
            mst.send_byte(b[i], k);
            ak[4-i] = k;
        end
        mst.stop();
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            burst_key_in = 1'b1;
            mst.idle(4);
            burst_key_in = 1'b0;
            mst.idle(4);
        end
        mst.idle(4);
    endtask
    initial begin
        logic [7:0] bad[3];
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        mst.idle(5);
        check({luma_reg, peak_reg}, 16'h0101);
        check({5'h00, dly}, {5'h00, PEI_DLY_W0});
        check({ctrans, sandc, coring, pdly, frq, gain, sda_oe_n}, {5'h00, 2'h1, 1'h1});
        bad = '{8'h89, 8'h8A, 8'h00};
        for (int i = 0; i < 3; i++) begin
            wr(bad[i], 8'h10, 8'h40, 8'h00, 8'h00, 1, acks);
            check({11'h000, acks}, 16'h0000);
            check({luma_reg, peak_reg}, 16'h0101);
        end
        bad = '{8'h00, 8'h0F, 8'h12};
        for (int i = 0; i < 3; i++) begin
            wr(8'h88, bad[i], 8'h40, 8'h00, 8'h00, 1, acks);
            check({11'h000, acks}, 16'h0010);
            check({luma_reg, peak_reg}, 16'h0101);
        end
        wr(8'h88, 8'h10, 8'hFF, 8'h00, 8'h00, 1, acks);
        check({11'h000, acks}, 16'h001C);
        check({8'h00, luma_reg}, 16'h007F);
        check({14'h0000, ctrans, sandc}, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            wr(8'h88, 8'h10, (i < 5) ? (8'h01 << i) : 8'h00, 8'h00, 8'h00, 1, acks);
            check({5'h00, dly}, wts[i][15:0]);
        end
        check({14'h0000, ctrans, sandc}, 16'h0000);
        wr(8'h88, 8'h10, 8'h20, 8'hFF, 8'h55, 3, acks);
        check({11'h000, acks}, 16'h001E);
        check({luma_reg, peak_reg}, 16'h20E3);
        check({ctrans, sandc, coring, pdly, frq, gain}, {5'h17, 2'h3});
        for (int g = 0; g < 4; g++) begin
            wr(8'h88, 8'h11, g[7:0], 8'h00, 8'h00, 1, acks);
            check({coring, pdly, frq, gain, peak_reg}, {3'h0, g[1:0], g[7:0]});
        end
        vblank_in = 1'b1;
        pulses(3);
        check({active, cnt}, 16'h0003);
        pulses(1);
        check({active, cnt}, 16'h0024);
        pulses(27);
        check({active, cnt}, 16'h003F);
        pulses(1);
        check({active, cnt}, 16'h0001);
        vblank_in = 1'b0;
        mst.idle(8);
        check({active, cnt}, 16'h0000);
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
